/* File: common/limit_stop_pkg.sv */
// Package: register map, codes and constants for the overtravel limit stop block
package limit_stop_pkg;
  localparam int          REG_ADDR_W           = 16;
  localparam logic [15:0] MODE_SEL_OFFSET      = 16'h3504;
  localparam logic [15:0] STOP_SEL_OFFSET      = 16'h3505;
  localparam logic [15:0] STOP_TORQUE_OFFSET   = 16'h3511;
  localparam logic [15:0] MODE_SEL_RESET       = 16'h0001;
  localparam logic [15:0] STOP_SEL_RESET       = 16'h0000;
  localparam logic [15:0] STOP_TORQUE_RESET    = 16'h0000;
  localparam logic [15:0] SEL_BOTH_OPEN        = 16'h0000;
  localparam logic [15:0] SEL_IGNORE           = 16'h0001;
  localparam logic [15:0] SEL_EITHER_OPEN      = 16'h0002;
  localparam logic [15:0] STOP_DYN_BRAKE       = 16'h0000;
  localparam logic [15:0] STOP_FREE_RUN        = 16'h0001;
  localparam logic [15:0] STOP_IMMEDIATE       = 16'h0002;
  localparam logic [7:0]  ERR_MAJOR_PROHIBIT   = 8'h26;
  localparam logic [3:0]  ERR_MINOR_PROHIBIT   = 4'h0;
  localparam logic [7:0]  ERR_MAJOR_OVERFLOW   = 8'h18;
  localparam logic [7:0]  ERR_MAJOR_OVERRUN    = 8'h22;
  localparam logic [7:0]  WARN_COMMAND         = 8'hB1;
  localparam logic [15:0] STOP_SPEED_RPM       = 16'h001E;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_DECEL  = 2'b01,
    ST_STOPPD = 2'b10,
    ST_FAULT  = 2'b11
  } stop_state_t;

  typedef enum logic [1:0] {
    BRK_NONE    = 2'b00,
    BRK_DYNAMIC = 2'b01,
    BRK_FREE    = 2'b10,
    BRK_CONTROL = 2'b11
  } brake_t;

  typedef struct packed {
    logic [7:0] major;
    logic [3:0] minor;
    logic       valid;
  } err_code_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage

/* File: dv/limit_switch_model.sv */
// Limit switch pair model: contacts stay closed unless the bench actuates them
`timescale 1ns/1ns
`default_nettype none
module limit_switch_model (
  // Clock
  input  wire logic clock_i,
  // Actuation commanded by the bench
  input  wire logic fwd_open_i,
  input  wire logic rev_open_i,
  // Contact levels, high when closed
  output var  logic fwd_closed_o,
  output var  logic rev_closed_o
);
  always_ff @(posedge clock_i) begin
    fwd_closed_o <= !fwd_open_i;
    rev_closed_o <= !rev_open_i;
  end
endmodule
`default_nettype wire

/* File: dv/overtravel_limit_stop_control_tb_top.sv */
// Testbench for the overtravel limit stop block against an integer reference model
`timescale 1ns/1ns
`default_nettype none
module overtravel_limit_stop_control_tb_top;
  import limit_stop_pkg::*;
  logic               clock_i = 1'b0;
  logic               rst_i   = 1'b1;
  reg_req_t           req     = '0;
  logic [15:0]        rdata;
  logic               fo = 1'b0, ro = 1'b0, fc, rc, cf = 1'b0, cr = 1'b0;
  logic               oerr = 1'b0, fclr = 1'b0, son, ecc, frx, fb, rb;
  logic               ovf = 1'b0, orun = 1'b0;
  logic [15:0]        spd = '0, tl_o, ntl = 16'h0200;
  logic signed [15:0] tq  = '0, tq_o;
  brake_t             brk;
  err_code_t          err;
  logic [7:0]         warn;
  brake_t             bexp[3] = '{BRK_DYNAMIC, BRK_FREE, BRK_CONTROL};
  int                 failures = 0, cmp_count = 0, seed = 93;
  int                 mode = 1, stop = 0, treg = 0, err_exp = 0;

  limit_switch_model sw (.clock_i(clock_i), .fwd_open_i(fo), .rev_open_i(ro), .fwd_closed_o(fc), .rev_closed_o(rc));

  overtravel_limit_stop_control uut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .forward_travel_limit_input_i(fc), .reverse_travel_limit_input_i(rc),
    .speed_abs_i(spd), .cmd_forward_i(cf), .cmd_reverse_i(cr), .torque_cmd_i(tq),
    .normal_torque_limit_i(ntl), .other_error_i(oerr), .pos_err_overflow_i(ovf),
    .overrun_i(orun), .fault_clear_i(fclr), .torque_cmd_o(tq_o), .torque_limit_o(tl_o),
    .brake_mode_o(brk), .servo_on_o(son), .err_counter_clear_o(ecc), .fault_reaction_o(frx),
    .error_o(err), .warning_o(warn), .fwd_blocked_o(fb), .rev_blocked_o(rb));

  always #10 clock_i = ~clock_i;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [15:0] a, input int d);
    @(posedge clock_i);
    req <= '{wr: 1'b1, addr: a, wdata: d[15:0]};
    @(posedge clock_i);
    req <= '{wr: 1'b0, addr: a, wdata: d[15:0]};
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clock_i);
    req <= '{wr: 1'b0, addr: a, wdata: 16'h0};
    tick(1);
    @(negedge clock_i);
    chk(what, exp, rdata);
  endtask

  task automatic cfg(input int m, input int s, input int t);
    mode = m;
    stop = s;
    treg = t;
    wr(16'h3504, m);
    wr(16'h3505, s);
    wr(16'h3511, t);
  endtask

  // Reference levels are worked out after the limit path has settled
  task automatic model_chk();
    int bf, br, w;
    tick(4);
    @(negedge clock_i);
    // Any selection but ignore marks an open limit as blocked
    bf = (mode != 1) && fo;
    br = (mode != 1) && ro;
    if ((mode == 0 && fo && ro) || (mode == 2 && (fo || ro))) err_exp = 1;
    w = (spd <= 30 && ((cf && bf) || (cr && br))) ? 32'hB1 : 0;
    chk("fwd_blocked", 16'(bf), {15'h0, fb});
    chk("rev_blocked", 16'(br), {15'h0, rb});
    chk("err_valid", 16'(err_exp), {15'h0, err.valid});
    chk("fault_reaction", 16'(err_exp), {15'h0, frx});
    if (err_exp) begin
      chk("err_code", 16'h0260, {err.major, err.minor});
    end else begin
      chk("warning", 16'(w), {8'h0, warn});
    end
  endtask

  task automatic clr();
    @(posedge clock_i);
    fo <= 1'b0;
    ro <= 1'b0;
    oerr <= 1'b0;
    fclr <= 1'b1;
    tick(5);
    fclr <= 1'b0;
    err_exp = 0;
    model_chk();
  endtask

  initial begin
    tick(20000);
    failures++;
    end_of_test();
  end

  initial begin
    tick(12);
    rst_i <= 1'b0;
    rd(16'h3504, 16'h0001, "mode_reset");
    rd(16'h3505, 16'h0000, "stop_reset");
    rd(16'h3511, 16'h0000, "torque_reset");
    rd(16'h3507, 16'h0000, "unmapped");
    $display("test registers done");
    @(posedge clock_i);
    fo <= 1'b1;
    ro <= 1'b1;
    model_chk();
    clr();
    $display("test ignore done");
    // Last pass repeats immediate stop with a zero torque setting
    for (int k = 0; k < 4; k++) begin
      cfg(0, (k > 2) ? 2 : k, (k == 2) ? 100 : 0);
      spd <= 16'(31 + {$random(seed)} % 900);
      tq <= 16'(1 + {$random(seed)} % 1000);
      tick(2);
      fo <= 1'b1;
      model_chk();
      chk("brake", {14'h0, bexp[stop]}, {14'h0, brk});
      chk("err_cnt_clear", 16'h0001, {15'h0, ecc});
      chk("servo_on", 16'(stop == 2), {15'h0, son});
      if (stop == 2) chk("torque_limit", (treg != 0) ? 16'(treg) : ntl, tl_o);
      @(posedge clock_i);
      spd <= 16'h001E;
      cf <= 1'b1;
      model_chk();
      chk("torque_cmd", (stop < 2) ? 16'h0 : tq, tq_o);
      @(posedge clock_i);
      cf <= 1'b0;
      spd <= 16'h0000;
      clr();
      $display("test stop selection %0d done", stop);
    end
    cfg(0, 0, 0);
    fo <= 1'b1;
    ro <= 1'b1;
    model_chk();
    clr();
    // vertical axis host picks stop selection 2
    cfg(2, 2, 0);
    rd(16'h3504, 16'h0002, "mode_written");
    @(posedge clock_i);
    ro <= 1'b1;
    model_chk();
    clr();
    $display("test prohibition errors done");
    @(posedge clock_i);
    oerr <= 1'b1;
    tick(4);
    @(negedge clock_i);
    chk("other_fault", 16'h0001, {15'h0, frx});
    clr();
    $display("test other error done");
    // Overflow and overrun are reported one cycle after their sources rise
    @(posedge clock_i);
    ovf <= 1'b1;
    @(posedge clock_i);
    ovf <= 1'b0;
    orun <= 1'b1;
    @(negedge clock_i);
    chk("overflow_code", 16'h0301, {3'h0, err});
    @(posedge clock_i);
    orun <= 1'b0;
    @(negedge clock_i);
    chk("overrun_code", 16'h0441, {3'h0, err});
    clr();
    $display("test error codes done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: rtl/overtravel_limit_stop_control.sv */
// Overtravel limit stop control: limit input handling, stop sequencing, warnings and faults
`timescale 1ns/1ns
`default_nettype none
module overtravel_limit_stop_control
  import limit_stop_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int TORQ_W  = 16
) (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  // Register access
  input  wire limit_stop_pkg::reg_req_t  reg_req_i,
  output var  logic [15:0]               reg_rdata_o,
  // Limit switch inputs, high when closed
  input  wire logic                      forward_travel_limit_input_i,
  input  wire logic                      reverse_travel_limit_input_i,
  // Motion state and commands
  input  wire logic [SPEED_W-1:0]        speed_abs_i,
  input  wire logic                      cmd_forward_i,
  input  wire logic                      cmd_reverse_i,
  input  wire logic signed [TORQ_W-1:0]  torque_cmd_i,
  input  wire logic [TORQ_W-1:0]         normal_torque_limit_i,
  input  wire logic                      other_error_i,
  input  wire logic                      pos_err_overflow_i,
  input  wire logic                      overrun_i,
  input  wire logic                      fault_clear_i,
  // Stop control outputs
  output var  logic signed [TORQ_W-1:0]  torque_cmd_o,
  output var  logic [TORQ_W-1:0]         torque_limit_o,
  output var  limit_stop_pkg::brake_t    brake_mode_o,
  output var  logic                      servo_on_o,
  output var  logic                      err_counter_clear_o,
  output var  logic                      fault_reaction_o,
  output var  limit_stop_pkg::err_code_t error_o,
  output var  logic [7:0]                warning_o,
  output var  logic                      fwd_blocked_o,
  output var  logic                      rev_blocked_o
);
  import limit_stop_pkg::*;

  logic [15:0]  mode_sel_q;
  logic [15:0]  stop_sel_q;
  logic [15:0]  stop_torque_q;
  stop_state_t  state_q;
  stop_state_t  state_d;
  logic         fwd_open;
  logic         rev_open;
  logic         prohibit_err;
  logic         slow;
  logic         fwd_open_q;
  logic         rev_open_q;

  function automatic logic is_low_speed(input logic [SPEED_W-1:0] spd);
    is_low_speed = spd <= SPEED_W'(STOP_SPEED_RPM);
  endfunction

  assign fwd_open = (mode_sel_q != SEL_IGNORE) && !forward_travel_limit_input_i;
  assign rev_open = (mode_sel_q != SEL_IGNORE) && !reverse_travel_limit_input_i;
  assign slow     = is_low_speed(speed_abs_i);

  always_comb begin
    case (mode_sel_q)
      SEL_BOTH_OPEN:   prohibit_err = fwd_open && rev_open;
      SEL_EITHER_OPEN: prohibit_err = fwd_open || rev_open;
      default:         prohibit_err = 1'b0;
    endcase
  end

  // Register writes; out-of-range values are kept so reads show what was written
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_sel_q    <= MODE_SEL_RESET;
      stop_sel_q    <= STOP_SEL_RESET;
      stop_torque_q <= STOP_TORQUE_RESET;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        MODE_SEL_OFFSET:    mode_sel_q    <= reg_req_i.wdata;
        STOP_SEL_OFFSET:    stop_sel_q    <= reg_req_i.wdata;
        STOP_TORQUE_OFFSET: stop_torque_q <= reg_req_i.wdata;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_req_i.addr)
        MODE_SEL_OFFSET:    reg_rdata_o <= mode_sel_q;
        STOP_SEL_OFFSET:    reg_rdata_o <= stop_sel_q;
        STOP_TORQUE_OFFSET: reg_rdata_o <= stop_torque_q;
        default:            reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_open_q <= 1'b0;
      rev_open_q <= 1'b0;
    end else begin
      fwd_open_q <= fwd_open;
      rev_open_q <= rev_open;
    end
  end

  // Stop sequence state; a fault always wins over the stop selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (prohibit_err || other_error_i) begin
          state_d = ST_FAULT;
        end else if (mode_sel_q == SEL_BOTH_OPEN &&
                     ((fwd_open && cmd_forward_i) || (rev_open && cmd_reverse_i) ||
                      (fwd_open && !fwd_open_q) || (rev_open && !rev_open_q))) begin
          state_d = slow ? ST_STOPPD : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (prohibit_err || other_error_i) begin
          state_d = ST_FAULT;
        end else if (slow) begin
          state_d = ST_STOPPD;
        end
      end
      ST_STOPPD: begin
        // Sticky regardless of speed; returns to run only when both limits close
        if (prohibit_err || other_error_i) begin
          state_d = ST_FAULT;
        end else if (!fwd_open && !rev_open) begin
          state_d = ST_RUN;
        end
      end
      ST_FAULT: begin
        if (fault_clear_i && !prohibit_err && !other_error_i) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // prohibition, overflow or overrun error code, in any stop state
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      error_o <= '0;
    end else if (prohibit_err) begin
      error_o <= '{major: ERR_MAJOR_PROHIBIT, minor: ERR_MINOR_PROHIBIT, valid: 1'b1};
    end else if (pos_err_overflow_i) begin
      error_o <= '{major: ERR_MAJOR_OVERFLOW, minor: 4'h0, valid: 1'b1};
    end else if (overrun_i) begin
      error_o <= '{major: ERR_MAJOR_OVERRUN, minor: 4'h0, valid: 1'b1};
    end else if (fault_clear_i) begin
      error_o <= '0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_blocked_o <= 1'b0;
      rev_blocked_o <= 1'b0;
    end else begin
      fwd_blocked_o <= fwd_open;
      rev_blocked_o <= rev_open;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      warning_o <= 8'h00;
    end else if (slow && ((fwd_open && cmd_forward_i) || (rev_open && cmd_reverse_i))) begin
      warning_o <= WARN_COMMAND;
    end else begin
      warning_o <= 8'h00;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      brake_mode_o        <= BRK_NONE;
      servo_on_o          <= 1'b1;
      err_counter_clear_o <= 1'b0;
      fault_reaction_o    <= 1'b0;
    end else begin
      fault_reaction_o    <= (state_d == ST_FAULT);
      err_counter_clear_o <= (state_d == ST_DECEL);
      brake_mode_o        <= BRK_NONE;
      servo_on_o          <= (state_d != ST_FAULT);
      if (state_d == ST_DECEL) begin
        case (stop_sel_q)
          STOP_DYN_BRAKE: begin
            brake_mode_o <= BRK_DYNAMIC;
            servo_on_o   <= 1'b0;
          end
          STOP_FREE_RUN: begin
            brake_mode_o <= BRK_FREE;
            servo_on_o   <= 1'b0;
          end
          default: brake_mode_o <= BRK_CONTROL;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      torque_cmd_o   <= '0;
      torque_limit_o <= '0;
    end else begin
      torque_cmd_o   <= torque_cmd_i;
      torque_limit_o <= normal_torque_limit_i;
      if (state_d == ST_DECEL && stop_sel_q == STOP_IMMEDIATE && stop_torque_q != 16'h0000) begin
        torque_limit_o <= TORQ_W'(stop_torque_q);
      end
      if (state_d == ST_STOPPD && stop_sel_q != STOP_IMMEDIATE &&
          ((fwd_open && torque_cmd_i > 0) || (rev_open && torque_cmd_i < 0))) begin
        torque_cmd_o <= '0;
      end
    end
  end

  chk_either_err: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_sel_q == SEL_EITHER_OPEN && (fwd_open || rev_open)) |=> error_o.valid)
    else $error("either open limit did not raise error");
  chk_ignore_inputs: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_sel_q == SEL_IGNORE && $stable(mode_sel_q)) |=> !fwd_blocked_o && !rev_blocked_o)
    else $error("limits not ignored under selection 1");
  chk_err_code: assert property (@(posedge clock_i) disable iff (rst_i)
    prohibit_err |=> error_o.major == ERR_MAJOR_PROHIBIT && error_o.minor == ERR_MINOR_PROHIBIT)
    else $error("wrong prohibition error code");
  chk_fwd_block: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_sel_q == SEL_BOTH_OPEN && !forward_travel_limit_input_i) |=> fwd_blocked_o)
    else $error("forward not blocked");
  chk_cmd_warning: assert property (@(posedge clock_i) disable iff (rst_i)
    (slow && fwd_open && cmd_forward_i) |=> warning_o == WARN_COMMAND)
    else $error("command warning missing");
  chk_decel_end: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == ST_DECEL && slow && !prohibit_err && !other_error_i) |=> state_q == ST_STOPPD)
    else $error("deceleration did not end at low speed");
  chk_counter_clr: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_d == ST_DECEL) |=> err_counter_clear_o)
    else $error("error counter not cleared");
  chk_fault_prio: assert property (@(posedge clock_i) disable iff (rst_i)
    other_error_i |=> fault_reaction_o && state_q == ST_FAULT)
    else $error("fault reaction not taken");
  chk_imm_servo: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_d == ST_DECEL && stop_sel_q == STOP_IMMEDIATE) |=> servo_on_o && brake_mode_o == BRK_CONTROL)
    else $error("immediate stop dropped servo");
  cov_decel: cover property (@(posedge clock_i) disable iff (rst_i) state_q == ST_DECEL ##1 state_q == ST_STOPPD);
  cov_fault: cover property (@(posedge clock_i) disable iff (rst_i) state_q == ST_FAULT);
  cov_warn:  cover property (@(posedge clock_i) disable iff (rst_i) warning_o == WARN_COMMAND);
endmodule
`default_nettype wire
